//--- core/adcmt_pkg.sv
/*
 package for the converter mode and timing control block: offsets,
 field layouts, reset values, encodings, timing constants and the
 count functions.
 assumes a single 25 MHz clock that stands in for the peripheral
 clock, so every interval is counted in cycles of that clock.
*/
// Operation
// - both mode registers are eight bits, reset to zero, byte or bit access
// - enable bit seven of register zero stops or enables conversion
// - mode field picks continuous or one-shot, select or scan
// - edge field picks none, falling, rising or both trigger edges
// - trigger mode bit picks software or hardware trigger
// - bit zero reads busy state, writes to it are ignored
// - high-speed continuous: busy config write aborts, software mode restarts
// - high-speed continuous hardware mode: busy config write aborts, back to trigger wait
// - bit seven picks normal or high speed, bits three..zero code
// - conversion lasts 26 cycles times code plus one, codes 0..11
// - stabilization 25, 26, 39 or 50 cycles, never below 1 us (25 cycles)
// - normal mode waits one conversion time after each conversion
// - trigger response delay is four cycles plus the code
// - after enabling, stabilize, then convert for the set time
// - normal mode raises the end interrupt when the wait expires
// - high speed raises the end interrupt right at conversion end
// - high-speed continuous stabilizes only before the first one
// - hardware source: pin edge, timer compare zero or one
// - result sits in upper ten of sixteen bits, low six zero
package adcmt_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [31:0] ADCMT_M0_OFS = 32'h0ffff200;
  localparam logic [31:0] ADCMT_M1_OFS = 32'hfffff201;
  localparam logic [31:0] ADCMT_CHSEL_OFS = 32'hfffff202;
  localparam logic [31:0] ADCMT_TRIGSEL_OFS = 32'hfffff203;
  localparam logic [7:0] ADCMT_REG_RST = 8'h00;
  localparam logic [7:0] ADCMT_M0_WMASK = 8'hbe;
  localparam logic [7:0] ADCMT_M1_WMASK = 8'h8f;
  localparam logic [7:0] ADCMT_CHSEL_WMASK = 8'h0f;
  localparam logic [7:0] ADCMT_TRIGSEL_WMASK = 8'h03;
  localparam int ADCMT_HS_BIT = 7;
  localparam int ADCMT_RES_PAD = 6;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] ADCMT_SRC_PIN = 2'h0;
  localparam logic [1:0] ADCMT_SRC_TMR0 = 2'h1;
  localparam logic [1:0] ADCMT_SRC_TMR1 = 2'h2;

  typedef struct packed {
    logic ce;
    logic rsv;
    logic oneshot;
    logic scan;
    logic edge_rise;
    logic edge_fall;
    logic tmd;
    logic ef;
  } adcmt_m0_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_STAB, ST_TRIG, ST_RESP, ST_CONV, ST_WAIT
  } adcmt_state_t;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int STAB_MIN_NS = 1000;
  localparam logic [9:0] STAB_MIN_CYC =
    10'((STAB_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [9:0] CONV_UNIT = 10'h01a;
  localparam logic [9:0] STAB_STEP = 10'h00d;
  localparam logic [9:0] STAB_SLOW = 10'h032;
  localparam logic [9:0] RESP_BASE = 10'h004;
  localparam logic [3:0] CODE_MAX = 4'hb;
  localparam logic [3:0] CODE_SLOW = 4'h3;

  // prohibited codes are held at the slowest legal one
  function automatic logic [9:0] adcmt_code(input logic [3:0] c);
    return {6'h00, (c > CODE_MAX) ? CODE_MAX : c};
  endfunction

  function automatic logic [9:0] adcmt_conv_cyc(input logic [3:0] c);
    return 10'(CONV_UNIT * (adcmt_code(c) + 10'h001));
  endfunction

  function automatic logic [9:0] adcmt_stab_cyc(input logic [3:0] c);
    logic [9:0] t;
    t = (c < CODE_SLOW) ? 10'(STAB_STEP * (adcmt_code(c) + 10'h001))
                        : STAB_SLOW;
    return (t < STAB_MIN_CYC) ? STAB_MIN_CYC : t;
  endfunction

  function automatic logic [9:0] adcmt_resp_cyc(input logic [3:0] c);
    return RESP_BASE + adcmt_code(c);
  endfunction

endpackage

//--- core/adcmt_ctrl.sv
/*
 mode and timing control of a ten-bit successive approximation
 converter: mode registers, trigger selection, interval sequencing,
 result capture and the conversion-end interrupt pulse.
 assumes the analog front end delivers its ten-bit answer on
 sar_data by the last conversion cycle, all inputs are synchronous
 to mclk, and writes to the power-fail registers elsewhere are
 reported on pf_cfg_wr.
*/
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module adcmt_ctrl
  import adcmt_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // register port
  input wire logic [31:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic pf_cfg_wr,
  // trigger sources
  input wire logic external_trigger_pin,
  input wire logic timer_compare0_irq,
  input wire logic timer_compare1_irq,
  // analog front end
  input wire logic [9:0] sar_data,
  output logic conv_active,
  output logic [3:0] conv_channel,
  // results and interrupt
  output logic [15:0] conversion_result_reg,
  output logic [3:0] result_channel,
  output logic result_valid,
  output logic conversion_end_irq
);

  // ---------------------------------------------------------------
  // registers and state
  // ---------------------------------------------------------------
  adcmt_m0_t m0_ff;
  logic [7:0] m1_ff;
  logic [7:0] chsel_ff;
  logic [7:0] trigsel_ff;
  logic [7:0] rdata_ff;
  logic ce_q_ff;
  logic pin_q_ff;
  adcmt_state_t state_ff, nxt_state;
  logic [9:0] cnt_ff, nxt_cnt;
  logic [3:0] idx_ff, nxt_idx;
  logic [15:0] res_ff;
  logic [3:0] res_ch_ff;
  logic res_vld_ff, nxt_res_vld;
  logic irq_ff, nxt_irq;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  wire hit_m0 = (reg_addr == ADCMT_M0_OFS);
  wire hit_m1 = (reg_addr == ADCMT_M1_OFS);
  wire hit_ch = (reg_addr == ADCMT_CHSEL_OFS);
  wire hit_tr = (reg_addr == ADCMT_TRIGSEL_OFS);
  wire wr_m0 = reg_wr & hit_m0;
  wire wr_m1 = reg_wr & hit_m1;
  wire wr_ch = reg_wr & hit_ch;
  wire wr_tr = reg_wr & hit_tr;
  wire cfg_wr = wr_m0 | wr_ch | wr_tr | pf_cfg_wr;

  // mode decode
  // speed bit and code
  wire hs = m1_ff[ADCMT_HS_BIT];
  wire [3:0] code = m1_ff[3:0];
  wire [9:0] conv_cyc = adcmt_conv_cyc(code);
  wire [9:0] stab_cyc = adcmt_stab_cyc(code);
  wire [9:0] resp_cyc = adcmt_resp_cyc(code);
  wire [3:0] last_ch = chsel_ff[3:0];
  wire busy = (state_ff == ST_STAB) | (state_ff == ST_RESP) |
              (state_ff == ST_CONV) | (state_ff == ST_WAIT);
  // start only on the enable edge
  wire ce_rise = m0_ff.ce & ~ce_q_ff;
  wire cnt_end = (cnt_ff == 10'h001);

  // ---------------------------------------------------------------
  // trigger selection
  // ---------------------------------------------------------------
  // edge detect on the external pin
  wire pin_fall = pin_q_ff & ~external_trigger_pin;
  wire pin_rise = ~pin_q_ff & external_trigger_pin;
  wire pin_hit = (m0_ff.edge_fall & pin_fall) |
                 (m0_ff.edge_rise & pin_rise);
  // source select, code three never fires
  wire hw_trig = (trigsel_ff[1:0] == ADCMT_SRC_PIN) ? pin_hit :
                 (trigsel_ff[1:0] == ADCMT_SRC_TMR0) ? timer_compare0_irq :
                 (trigsel_ff[1:0] == ADCMT_SRC_TMR1) ? timer_compare1_irq :
                 1'b0;

  // only high-speed continuous runs take the abort path
  wire abort = cfg_wr & busy & hs & ~m0_ff.oneshot & m0_ff.ce;

  // scan walks channels up to the selected one
  wire seq_end = ~m0_ff.scan | (idx_ff == last_ch);

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // byte-wide registers, reserved bits forced to zero
  // bit zero of mode register zero never stored from a write
  always_ff @(posedge mclk) begin
    if (reset) begin
      m0_ff <= ADCMT_REG_RST;
      m1_ff <= ADCMT_REG_RST;
      chsel_ff <= ADCMT_REG_RST;
      trigsel_ff <= ADCMT_REG_RST;
    end else begin
      if (wr_m0) m0_ff <= reg_wdata & ADCMT_M0_WMASK;
      if (wr_m1) m1_ff <= reg_wdata & ADCMT_M1_WMASK;
      if (wr_ch) chsel_ff <= reg_wdata & ADCMT_CHSEL_WMASK;
      if (wr_tr) trigsel_ff <= reg_wdata & ADCMT_TRIGSEL_WMASK;
    end
  end

  // read data, busy shown live in bit zero
  wire [7:0] m0_rd = {m0_ff[7:1], busy};
  wire [7:0] rd_mux = hit_m0 ? m0_rd :
                      hit_m1 ? m1_ff :
                      hit_ch ? chsel_ff :
                      hit_tr ? trigsel_ff : 8'h00;

  // read answer stands one cycle only, zero otherwise
  always_ff @(posedge mclk) begin
    if (reset) rdata_ff <= 8'h00;
    else rdata_ff <= reg_rd ? rd_mux : 8'h00;
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  // next step after a conversion, shared by both speed modes
  adcmt_state_t after_st;
  logic [9:0] after_cnt;
  always_comb begin
    after_st = ST_CONV;
    after_cnt = conv_cyc;
    if (seq_end & m0_ff.oneshot & ~m0_ff.tmd) begin
      after_st = ST_IDLE;
      after_cnt = 10'h000;
    end else if (seq_end & m0_ff.tmd) begin
      after_st = ST_TRIG;
      after_cnt = 10'h000;
    end else if (~hs) begin
      after_st = ST_STAB;
      after_cnt = stab_cyc;
    end
  end

  // one down counter for every interval
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = (cnt_ff == 10'h000) ? 10'h000 : cnt_ff - 10'h001;
    nxt_idx = idx_ff;
    nxt_res_vld = 1'b0;
    nxt_irq = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        nxt_idx = 4'h0;
        if (ce_rise) begin
          nxt_state = ST_STAB;
          nxt_cnt = stab_cyc;
        end
      end
      ST_STAB: begin
        if (cnt_end) begin
          nxt_state = m0_ff.tmd ? ST_TRIG : ST_CONV;
          nxt_cnt = m0_ff.tmd ? 10'h000 : conv_cyc;
        end
      end
      ST_TRIG: begin
        if (hw_trig) begin
          nxt_state = ST_RESP;
          nxt_cnt = resp_cyc;
        end
      end
      ST_RESP: begin
        if (cnt_end) begin
          nxt_state = ST_CONV;
          nxt_cnt = conv_cyc;
        end
      end
      ST_CONV: begin
        if (cnt_end) begin
          nxt_res_vld = 1'b1;
          nxt_idx = seq_end ? 4'h0 : idx_ff + 4'h1;
          if (hs) begin
            // interrupt at once in high speed
            nxt_irq = 1'b1;
            nxt_state = after_st;
            nxt_cnt = after_cnt;
          end else begin
            // wait as long as the conversion
            nxt_state = ST_WAIT;
            nxt_cnt = conv_cyc;
          end
        end
      end
      ST_WAIT: begin
        if (cnt_end) begin
          nxt_irq = 1'b1;
          nxt_state = after_st;
          nxt_cnt = after_cnt;
        end
      end
    endcase
    if (abort) begin
      nxt_idx = 4'h0;
      nxt_res_vld = 1'b0;
      nxt_irq = 1'b0;
      // hardware mode returns to trigger wait
      nxt_state = m0_ff.tmd ? ST_TRIG : ST_CONV;
      nxt_cnt = m0_ff.tmd ? 10'h000 : conv_cyc;
    end
    if (~m0_ff.ce) begin
      nxt_state = ST_IDLE;
      nxt_cnt = 10'h000;
      nxt_idx = 4'h0;
      nxt_irq = 1'b0;
      nxt_res_vld = 1'b0;
    end
  end

  // sequencer state, kept apart from the result capture
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 10'h000;
      idx_ff <= 4'h0;
      ce_q_ff <= 1'b0;
      pin_q_ff <= 1'b0;
      irq_ff <= 1'b0;
      res_vld_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      idx_ff <= nxt_idx;
      ce_q_ff <= m0_ff.ce;
      pin_q_ff <= external_trigger_pin;
      irq_ff <= nxt_irq;
      res_vld_ff <= nxt_res_vld;
    end
  end

  // result left aligned, low bits zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      res_ff <= 16'h0000;
      res_ch_ff <= 4'h0;
    end else if (nxt_res_vld) begin
      res_ff <= {sar_data, {ADCMT_RES_PAD{1'b0}}};
      res_ch_ff <= conv_channel;
    end
  end

  // outputs
  assign reg_rdata = rdata_ff;
  assign conv_active = (state_ff == ST_CONV);
  assign conv_channel = m0_ff.scan ? idx_ff : last_ch;
  assign conversion_result_reg = res_ff;
  assign result_channel = res_ch_ff;
  assign result_valid = res_vld_ff;
  assign conversion_end_irq = irq_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence conv_last_s;
    state_ff == ST_CONV && cnt_end && !abort && m0_ff.ce;
  endsequence

  sequence conv_entry_s;
    state_ff != ST_CONV ##1 state_ff == ST_CONV;
  endsequence

  busy_read_a: assert property (
    reg_rd && hit_m0 |=> reg_rdata[0] == $past(busy))
    else $error("busy bit does not follow the sequencer");
  stab_load_a: assert property (
    state_ff == ST_IDLE && ce_rise && m0_ff.ce |=> state_ff == ST_STAB
      && cnt_ff == adcmt_stab_cyc(code) && cnt_ff >= STAB_MIN_CYC)
    else $error("stabilization count wrong");
  conv_len_a: assert property (
    conv_entry_s |-> cnt_ff == adcmt_conv_cyc(code))
    else $error("conversion count wrong");
  hs_irq_a: assert property (
    conv_last_s ##0 hs |=> conversion_end_irq && result_valid)
    else $error("high speed interrupt not at conversion end");
  norm_wait_a: assert property (
    conv_last_s ##0 !hs |=> !conversion_end_irq && state_ff == ST_WAIT
      && cnt_ff == adcmt_conv_cyc(code))
    else $error("normal wait not inserted");
  resp_delay_a: assert property (
    state_ff == ST_TRIG && hw_trig && m0_ff.ce && !abort
      |=> state_ff == ST_RESP && cnt_ff == RESP_BASE + adcmt_code(code))
    else $error("trigger response count wrong");
  ce_stop_a: assert property (
    !m0_ff.ce |=> state_ff == ST_IDLE && !conversion_end_irq)
    else $error("disabled converter still active");
  sw_abort_a: assert property (
    abort && !m0_ff.tmd |=> conv_active && cnt_ff == conv_cyc)
    else $error("software abort did not restart");
  hw_abort_a: assert property (
    abort && m0_ff.tmd |=> state_ff == ST_TRIG && !busy)
    else $error("hardware abort did not return to trigger wait");
  res_pad_a: assert property (
    $rose(result_valid) |-> conversion_result_reg[5:0] == 6'h00
      && conversion_result_reg[15:6] == $past(sar_data))
    else $error("result not left aligned");
  stab_conv_a: assert property (
    state_ff == ST_STAB && cnt_end && !m0_ff.tmd && m0_ff.ce
      |=> conv_active && cnt_ff == adcmt_conv_cyc(code))
    else $error("conversion did not follow stabilization");
  wait_irq_a: assert property (
    state_ff == ST_WAIT && cnt_end && m0_ff.ce |=> conversion_end_irq)
    else $error("interrupt missing after the wait");
  hs_cont_a: assert property (
    conv_last_s ##0 (hs && !m0_ff.oneshot && !m0_ff.tmd)
      |=> conv_active && cnt_ff == adcmt_conv_cyc(code))
    else $error("high speed continuous run stabilized again");

endmodule

//--- bench/tb_top.sv
/*
 self-checking bench for the converter mode and timing control block.
 assumes the design package and one 25 MHz clock; bench drives all ports.
*/
`timescale 1ns/1ps
module tb_top import adcmt_pkg::*;;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] reg_addr = 32'h00000000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic pf_cfg_wr = 1'b0;
  logic external_trigger_pin = 1'b0;
  logic timer_compare0_irq = 1'b0;
  logic timer_compare1_irq = 1'b0;
  logic [9:0] sar_data = 10'h2a5;
  logic conv_active;
  logic [3:0] conv_channel;
  logic [15:0] conversion_result_reg;
  logic [3:0] result_channel;
  logic result_valid;
  logic conversion_end_irq;
  int n_fail = 0;
  int checked = 0;

  adcmt_ctrl i_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pf_cfg_wr(pf_cfg_wr),
    .external_trigger_pin(external_trigger_pin),
    .timer_compare0_irq(timer_compare0_irq),
    .timer_compare1_irq(timer_compare1_irq), .sar_data(sar_data),
    .conv_active(conv_active), .conv_channel(conv_channel),
    .conversion_result_reg(conversion_result_reg),
    .result_channel(result_channel), .result_valid(result_valid),
    .conversion_end_irq(conversion_end_irq));

  // 40 ns clock
  // bench runs on one main clock only
  always #20 mclk = ~mclk;

  // ----------------------------------------------------------------
  // compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // cycle counts are bench-side values, never unknown
  task automatic chk_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("counts: checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // bus and stimulus helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [31:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic pulse(input int which);
    @(posedge mclk);
    if (which == 0) timer_compare0_irq <= 1'b1;
    else timer_compare1_irq <= 1'b1;
    @(posedge mclk);
    timer_compare0_irq <= 1'b0;
    timer_compare1_irq <= 1'b0;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return conv_active;
      1: return result_valid;
      default: return conversion_end_irq;
    endcase
  endfunction

  // count edges until an output is high; 0 means it never came
  task automatic wait_for(input int s, input int max, output int n);
    n = 0;
    for (int i = 1; i <= max; i++) begin
      @(posedge mclk);
      #1;
      if (sig(s) === 1'b1) begin
        n = i;
        break;
      end
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset and masks
  task automatic t_regs;
    logic [7:0] d;
    rd(ADCMT_M0_OFS, d);
    chk_reg(d, 8'h00);
    rd(ADCMT_M1_OFS, d);
    chk_reg(d, 8'h00);
    wr(ADCMT_M0_OFS, 8'h7f);
    rd(ADCMT_M0_OFS, d);
    chk_reg(d, 8'h3e);
    wr(ADCMT_M1_OFS, 8'h8b);
    rd(ADCMT_M1_OFS, d);
    chk_reg(d, 8'h8b);
    rd(32'hfffff2ff, d);
    chk_reg(d, 8'h00);
    wr(ADCMT_M0_OFS, 8'h00);
    // code two: 78 cycles, 3.12 us at 25 MHz
    wr(ADCMT_M1_OFS, 8'h82);
    $display("test regs done");
  endtask

  // high-speed one-shot, code 2: S = 39, C = 78
  task automatic t_oneshot;
    int n;
    logic [7:0] d;
    wr(ADCMT_CHSEL_OFS, 8'h03);
    wr(ADCMT_M0_OFS, 8'ha0);
    wait_for(0, 100, n);
    chk_cnt(n, 40);
    chk_reg({4'h0, conv_channel}, 8'h03);
    wait_for(1, 400, n);
    chk_cnt(n, 78);
    chk_reg({7'h00, conversion_end_irq}, 8'h01);
    chk_data(conversion_result_reg, 16'ha940);
    chk_reg({4'h0, result_channel}, 8'h03);
    wait_for(0, 60, n);
    chk_cnt(n, 0);
    rd(ADCMT_M0_OFS, d);
    chk_reg(d, 8'ha0);
    wr(ADCMT_M0_OFS, 8'h00);
    // one-shot scan over channels 0 and 1
    wr(ADCMT_CHSEL_OFS, 8'h01);
    wr(ADCMT_M0_OFS, 8'hb0);
    wait_for(0, 100, n);
    chk_reg({4'h0, conv_channel}, 8'h00);
    wait_for(1, 100, n);
    chk_reg({4'h0, result_channel}, 8'h00);
    wait_for(0, 100, n);
    chk_reg({4'h0, conv_channel}, 8'h01);
    wait_for(1, 100, n);
    chk_reg({4'h0, result_channel}, 8'h01);
    wait_for(0, 100, n);
    chk_cnt(n, 0);
    wr(ADCMT_M0_OFS, 8'h00);
    $display("test oneshot done");
  endtask

  // normal mode waits one conversion time before the irq
  task automatic t_normal;
    int n;
    wr(ADCMT_M1_OFS, 8'h03);
    wr(ADCMT_M0_OFS, 8'ha0);
    wait_for(0, 200, n);
    chk_cnt(n, 51);
    wait_for(1, 400, n);
    chk_cnt(n, 104);
    chk_reg({7'h00, conversion_end_irq}, 8'h00);
    wait_for(2, 400, n);
    chk_cnt(n, 104);
    wr(ADCMT_M0_OFS, 8'h00);
    $display("test normal done");
  endtask

  // pin edges and response delay (code 2, R = 6)
  task automatic t_edges;
    logic [7:0] cfg [4] = '{8'h8a, 8'h86, 8'h82, 8'h8e};
    logic pv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    logic [7:0] d;
    int n;
    // hardware triggers run here in high speed, code 2
    wr(ADCMT_M1_OFS, 8'h82);
    wr(ADCMT_TRIGSEL_OFS, {6'h00, ADCMT_SRC_PIN});
    for (int k = 0; k < 4; k++) begin
      wr(ADCMT_M0_OFS, 8'h00);
      wr(ADCMT_M0_OFS, cfg[k]);
      wait_for(0, 50, n);
      chk_cnt(n, 0);
      @(posedge mclk);
      external_trigger_pin <= pv[k];
      wait_for(0, 20, n);
      if (k == 2) begin
        chk_cnt(n, 0);
      end else begin
        chk_cnt(n, 7);
        rd(ADCMT_M0_OFS, d);
        chk_reg(d, cfg[k] | 8'h01);
        wait_for(1, 100, n);
        chk_cnt(n, 76);
      end
    end
    wr(ADCMT_M0_OFS, 8'h00);
    $display("test edges done");
  endtask

  // timer sources: only the selected one triggers
  task automatic t_timers;
    int n;
    logic [7:0] d;
    for (int s = 1; s <= 2; s++) begin
      wr(ADCMT_M0_OFS, 8'h00);
      wr(ADCMT_TRIGSEL_OFS, 8'(s));
      wr(ADCMT_M0_OFS, 8'h82);
      wait_for(0, 50, n);
      chk_cnt(n, 0);
      pulse(2 - s);
      wait_for(0, 20, n);
      chk_cnt(n, 0);
      pulse(s - 1);
      wait_for(0, 20, n);
      chk_cnt(n, 6);
      // busy config write returns to trigger wait
      wr(ADCMT_CHSEL_OFS, 8'h00);
      wait_for(1, 100, n);
      chk_cnt(n, 0);
      rd(ADCMT_M0_OFS, d);
      chk_reg(d, 8'h82);
    end
    wr(ADCMT_M0_OFS, 8'h00);
    $display("test timers done");
  endtask

  // busy write restarts, no re-stab, disable
  task automatic t_abort;
    int n;
    logic [7:0] d;
    wr(ADCMT_TRIGSEL_OFS, 8'h00);
    wr(ADCMT_M1_OFS, 8'h82);
    wr(ADCMT_CHSEL_OFS, 8'h00);
    wr(ADCMT_M0_OFS, 8'h80);
    wait_for(0, 60, n);
    chk_cnt(n, 40);
    wait_for(1, 100, n);
    chk_cnt(n, 78);
    wait_for(1, 100, n);
    chk_cnt(n, 78);
    repeat (10) @(posedge mclk);
    wr(ADCMT_CHSEL_OFS, 8'h02);
    wait_for(1, 100, n);
    chk_cnt(n, 78);
    chk_reg({4'h0, result_channel}, 8'h02);
    // power-fail register write counts as a config write
    @(posedge mclk);
    pf_cfg_wr <= 1'b1;
    @(posedge mclk);
    pf_cfg_wr <= 1'b0;
    wait_for(1, 100, n);
    chk_cnt(n, 78);
    wr(ADCMT_M0_OFS, 8'h00);
    wait_for(0, 60, n);
    chk_cnt(n, 0);
    rd(ADCMT_M0_OFS, d);
    chk_reg(d, 8'h00);
    $display("test abort done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_oneshot();
    t_normal();
    t_edges();
    t_timers();
    t_abort();
    end_of_test();
  end

  // whole run is a few thousand cycles; allow ample margin
  initial begin
    #(40 * 30000);
    n_fail++;
    end_of_test();
  end
endmodule
